// >>> rtl/dcr_map.svh
// register offsets, field positions and reset values of the config bank
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH

`define DCR_ADDR_IFACE 5'h00
`define DCR_ADDR_INTERP 5'h01
`define DCR_ADDR_INPUT 5'h02
`define DCR_ADDR_Q_FINE 5'h09
`define DCR_ADDR_Q_COARSE 5'h0a
`define DCR_ADDR_Q_OFS_HI 5'h0b
`define DCR_ADDR_Q_OFS_LO 5'h0c
`define DCR_ADDR_VERSION 5'h0d

`define DCR_BIT_SDIO_BIDIR 7
`define DCR_BIT_LSB_FIRST 6
`define DCR_BIT_SOFT_RESET 5
`define DCR_BIT_SLEEP 4
`define DCR_BIT_POWER_DOWN 3
`define DCR_BIT_ONE_RES 2
`define DCR_BIT_PLL_LOCK 1

`define DCR_BIT_ZERO_STUFF 3
`define DCR_BIT_REAL_MIX 2
`define DCR_BIT_POS_EXP 1
`define DCR_BIT_PIN_RATE_CLK 0

`define DCR_BIT_OFFSET_BIN 7
`define DCR_BIT_ONE_PORT 6
`define DCR_BIT_STRONG_DRV 5
`define DCR_BIT_RATE_INV 4
`define DCR_BIT_SPCLK_INV 2
`define DCR_BIT_SEL_INV 1
`define DCR_BIT_Q_FIRST 0

`define DCR_BIT_INSTR_READ 7
`define DCR_BIT_OFS_DIR 7

`define DCR_MASK_IFACE 8'hdc
`define DCR_MASK_INTERP 8'hff
`define DCR_MASK_INPUT 8'hf7
`define DCR_MASK_Q_FINE 8'hff
`define DCR_MASK_Q_COARSE 8'h0f
`define DCR_MASK_Q_OFS_HI 8'hff
`define DCR_MASK_Q_OFS_LO 8'h83

`define DCR_RST_IFACE 8'h00
`define DCR_RST_INTERP 8'h04
`define DCR_RST_INPUT 8'h00
`define DCR_RST_Q_FINE 8'h00
`define DCR_RST_Q_COARSE 8'h00
`define DCR_RST_Q_OFS_HI 8'h00
`define DCR_RST_Q_OFS_LO 8'h00

`endif

// >>> rtl/dcr_pkg.sv
// types shared by the config register bank
package dcr_pkg;

    // decoded settings handed to the converter datapath
    typedef struct packed {
        logic [1:0] interp_sel;
        logic [1:0] mod_sel;
        logic zero_stuff;
        logic real_mix;
        logic pos_exponent;
        logic one_resistor;
        logic offset_binary;
        logic one_port;
        logic strong_drive;
        logic q_first;
        logic [7:0] q_fine;
        logic [3:0] q_coarse;
        logic [9:0] q_offset;
        logic q_offset_to_b;
    } dcr_cfg_t;

    typedef struct packed {
        logic [7:0] r_iface;
        logic [7:0] r_interp;
        logic [7:0] r_input;
        logic [7:0] r_q_fine;
        logic [7:0] r_q_coarse;
        logic [7:0] r_q_ofs_hi;
        logic [7:0] r_q_ofs_lo;
        logic sclk_prev;
        logic data_phase;
        logic read_op;
        logic [2:0] bit_cnt;
        logic [7:0] shift_in;
        logic [7:0] shift_out;
        logic [4:0] addr;
        logic dout;
    } dcr_state_t;

endpackage

// >>> rtl/dcr_config_bank.sv
// serial-port configuration and status register bank of the dual converter
//
// Operation
// - sdio drives only when bidir bit set, read
// - bit-order bit picks msb or lsb first
// - soft reset restores defaults, reads zero
// - soft reset spares reg 0; pin resets all
// - sleep turns off converter output currents
// - power-down stops all but serial port
// - one-resistor mode halves full-scale currents
// - lock bit reports pll lock state
// - interpolation field selects 1x 2x 4x 8x
// - modulation field: none, fs/2, fs/4, fs/8
// - zero-stuff bit enables zero insertion
// - mix bit: real default, clear complex
// - sign bit picks negative or positive exponent
// - two-port pin carries lock or rate clock
// - format bit: twos complement or straight binary
// - port bit: two-port default, one-port interleaved
// - drive bit strengthens rate clock driver
// - invert bit flips rate clock output pin
// - invert bit flips single-port clock pin
// - select polarity maps select input to channel
// - pair order bit: iq or qi pairs
// - q fine gain is eight-bit unsigned
// - q offset is ten bits, high then low
// - direction bit steers offset to output a/b
`include "dcr_map.svh"

module dcr_config_bank
    import dcr_pkg::*;
#(
    parameter logic [7:0] VERSION_ID = 8'h01 // arbitrary value
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic hw_reset_pin_in,
    input wire logic port_sclk_in,
    input wire logic port_cs_n_in,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe_n_out,
    output logic sdo_out,
    input wire logic pll_locked_in,
    input wire logic rate_clock_in,
    input wire logic single_port_clock_in,
    input wire logic channel_select_input_in,
    output logic rate_clock_out,
    output logic single_port_clock_pin_out,
    output logic route_to_q_out,
    output logic dac_current_on_out,
    output logic core_run_out,
    output dcr_cfg_t cfg_out
);

    dcr_state_t q, d;
    logic rst;
    logic sclk_rise;
    logic byte_done;
    logic [7:0] next_byte;
    logic wr_en;
    logic soft_rst;
    logic [7:0] rd_val;

    assign rst = sys_rst_in | hw_reset_pin_in;

    // ----------------------------------------------------------------
    // register read mux
    // ----------------------------------------------------------------
    function automatic logic [7:0] read_reg(input dcr_state_t s,
                                            input logic [4:0] a,
                                            input logic lock);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `DCR_ADDR_IFACE: begin
                v = s.r_iface & `DCR_MASK_IFACE;
                v[`DCR_BIT_PLL_LOCK] = lock;
            end
            `DCR_ADDR_INTERP: v = s.r_interp;
            `DCR_ADDR_INPUT: v = s.r_input & `DCR_MASK_INPUT;
            `DCR_ADDR_Q_FINE: v = s.r_q_fine;
            `DCR_ADDR_Q_COARSE: v = s.r_q_coarse & `DCR_MASK_Q_COARSE;
            `DCR_ADDR_Q_OFS_HI: v = s.r_q_ofs_hi;
            `DCR_ADDR_Q_OFS_LO: v = s.r_q_ofs_lo & `DCR_MASK_Q_OFS_LO;
            `DCR_ADDR_VERSION: v = VERSION_ID;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ----------------------------------------------------------------
    // serial shift and register update
    // ----------------------------------------------------------------
    assign sclk_rise = port_sclk_in & ~q.sclk_prev & ~port_cs_n_in;
    assign byte_done = sclk_rise & (q.bit_cnt == 3'd7);
    assign next_byte = q.r_iface[`DCR_BIT_LSB_FIRST]
        ? {sdio_in, q.shift_in[7:1]} : {q.shift_in[6:0], sdio_in};
    assign wr_en = byte_done & q.data_phase & ~q.read_op;
    assign soft_rst = wr_en & (q.addr == `DCR_ADDR_IFACE)
        & next_byte[`DCR_BIT_SOFT_RESET];
    assign rd_val = read_reg(q, `DCR_ADDR_IFACE, pll_locked_in);

    always_comb begin
        d = q;
        d.sclk_prev = port_sclk_in;
        if (port_cs_n_in) begin
            d.data_phase = 1'b0;
            d.bit_cnt = 3'd0;
        end else if (sclk_rise) begin
            d.shift_in = next_byte;
            d.bit_cnt = q.bit_cnt + 3'd1;
        end
        if (byte_done && !q.data_phase) begin
            d.data_phase = 1'b1;
            d.read_op = next_byte[`DCR_BIT_INSTR_READ];
            d.addr = next_byte[4:0];
            d.shift_out = read_reg(q, next_byte[4:0], pll_locked_in);
        end else if (byte_done) begin
            d.addr = q.addr + 5'd1;
            d.shift_out = read_reg(q, q.addr + 5'd1, pll_locked_in);
        end
        if (wr_en) begin
            unique case (q.addr)
                `DCR_ADDR_IFACE: d.r_iface = next_byte & `DCR_MASK_IFACE;
                `DCR_ADDR_INTERP: d.r_interp = next_byte;
                `DCR_ADDR_INPUT: d.r_input = next_byte & `DCR_MASK_INPUT;
                `DCR_ADDR_Q_FINE: d.r_q_fine = next_byte;
                `DCR_ADDR_Q_COARSE:
                    d.r_q_coarse = next_byte & `DCR_MASK_Q_COARSE;
                `DCR_ADDR_Q_OFS_HI: d.r_q_ofs_hi = next_byte;
                `DCR_ADDR_Q_OFS_LO:
                    d.r_q_ofs_lo = next_byte & `DCR_MASK_Q_OFS_LO;
                default: d.r_iface = d.r_iface;
            endcase
        end
        if (soft_rst) begin
            // reg 0 keeps what was just written
            d.r_interp = `DCR_RST_INTERP;
            d.r_input = `DCR_RST_INPUT;
            d.r_q_fine = `DCR_RST_Q_FINE;
            d.r_q_coarse = `DCR_RST_Q_COARSE;
            d.r_q_ofs_hi = `DCR_RST_Q_OFS_HI;
            d.r_q_ofs_lo = `DCR_RST_Q_OFS_LO;
        end
        // present the bit for the next rising edge
        if (q.r_iface[`DCR_BIT_LSB_FIRST]) begin
            d.dout = d.shift_out[d.bit_cnt];
        end else begin
            d.dout = d.shift_out[3'd7 - d.bit_cnt];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst) begin
            q <= '0;
            q.r_iface <= `DCR_RST_IFACE;
            q.r_interp <= `DCR_RST_INTERP;
            q.r_input <= `DCR_RST_INPUT;
            q.r_q_fine <= `DCR_RST_Q_FINE;
            q.r_q_coarse <= `DCR_RST_Q_COARSE;
            q.r_q_ofs_hi <= `DCR_RST_Q_OFS_HI;
            q.r_q_ofs_lo <= `DCR_RST_Q_OFS_LO;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // pins and decoded settings
    // ----------------------------------------------------------------
    assign sdio_out = q.dout;
    assign sdo_out = q.dout;
    assign sdio_oe_n_out = ~(q.r_iface[`DCR_BIT_SDIO_BIDIR] & q.data_phase
        & q.read_op & ~port_cs_n_in);

    assign dac_current_on_out = ~q.r_iface[`DCR_BIT_SLEEP]
        & ~q.r_iface[`DCR_BIT_POWER_DOWN];
    assign core_run_out = ~q.r_iface[`DCR_BIT_POWER_DOWN];

    assign rate_clock_out = (~q.r_input[`DCR_BIT_ONE_PORT]
        & ~q.r_interp[`DCR_BIT_PIN_RATE_CLK]) ? pll_locked_in
        : rate_clock_in ^ q.r_input[`DCR_BIT_RATE_INV];
    assign single_port_clock_pin_out =
        single_port_clock_in ^ q.r_input[`DCR_BIT_SPCLK_INV];
    assign route_to_q_out =
        channel_select_input_in ^ q.r_input[`DCR_BIT_SEL_INV];

    always_comb begin
        cfg_out.interp_sel = q.r_interp[7:6];
        cfg_out.mod_sel = q.r_interp[5:4];
        cfg_out.zero_stuff = q.r_interp[`DCR_BIT_ZERO_STUFF];
        cfg_out.real_mix = q.r_interp[`DCR_BIT_REAL_MIX];
        cfg_out.pos_exponent = q.r_interp[`DCR_BIT_POS_EXP];
        cfg_out.one_resistor = q.r_iface[`DCR_BIT_ONE_RES];
        cfg_out.offset_binary = q.r_input[`DCR_BIT_OFFSET_BIN];
        cfg_out.one_port = q.r_input[`DCR_BIT_ONE_PORT];
        cfg_out.strong_drive = q.r_input[`DCR_BIT_STRONG_DRV];
        cfg_out.q_first = q.r_input[`DCR_BIT_Q_FIRST];
        cfg_out.q_fine = q.r_q_fine;
        cfg_out.q_coarse = q.r_q_coarse[3:0];
        cfg_out.q_offset = {q.r_q_ofs_hi, q.r_q_ofs_lo[1:0]};
        cfg_out.q_offset_to_b = q.r_q_ofs_lo[`DCR_BIT_OFS_DIR];
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_sdio_input_only: assert property (@(posedge core_clk_in)
        disable iff (rst) !q.r_iface[`DCR_BIT_SDIO_BIDIR] |-> sdio_oe_n_out)
        else $error("sdio driven while bidir bit clear");

    a_lsb_shift_in: assert property (@(posedge core_clk_in)
        disable iff (rst)
        sclk_rise && q.r_iface[`DCR_BIT_LSB_FIRST]
        |=> q.shift_in[7] == $past(sdio_in))
        else $error("lsb-first shift took wrong bit");

    a_reset_bit_zero: assert property (@(posedge core_clk_in)
        disable iff (rst) rd_val[`DCR_BIT_SOFT_RESET] == 1'b0)
        else $error("soft reset bit read back as one");

    a_soft_reset_keep: assert property (@(posedge core_clk_in)
        disable iff (rst) soft_rst
        |=> q.r_interp == `DCR_RST_INTERP && q.r_q_fine == `DCR_RST_Q_FINE
            && q.r_iface == ($past(next_byte) & `DCR_MASK_IFACE))
        else $error("soft reset handled reg 0 or defaults wrongly");

    a_hard_reset_all: assert property (@(posedge core_clk_in)
        rst |=> q.r_iface == `DCR_RST_IFACE && q.r_interp == `DCR_RST_INTERP
            && q.r_input == `DCR_RST_INPUT)
        else $error("pin reset left a register off default");

    a_sleep_currents: assert property (@(posedge core_clk_in)
        disable iff (rst) $rose(q.r_iface[`DCR_BIT_SLEEP])
        |-> !dac_current_on_out && core_run_out == !q.r_iface[3])
        else $error("sleep left output currents on");

    a_power_down_core: assert property (@(posedge core_clk_in)
        disable iff (rst) q.r_iface[`DCR_BIT_POWER_DOWN]
        |-> !core_run_out && !dac_current_on_out)
        else $error("power-down left core running");

    a_lock_status: assert property (@(posedge core_clk_in)
        disable iff (rst) rd_val[`DCR_BIT_PLL_LOCK] == pll_locked_in)
        else $error("lock bit disagrees with pll");

    a_lock_on_pin: assert property (@(posedge core_clk_in)
        disable iff (rst) !q.r_input[`DCR_BIT_ONE_PORT]
        && !q.r_interp[`DCR_BIT_PIN_RATE_CLK]
        |-> rate_clock_out == pll_locked_in)
        else $error("shared pin not carrying lock");

    a_channel_route: assert property (@(posedge core_clk_in)
        disable iff (rst) route_to_q_out
        == (channel_select_input_in != q.r_input[`DCR_BIT_SEL_INV]))
        else $error("channel routing polarity wrong");

    a_offset_word: assert property (@(posedge core_clk_in)
        disable iff (rst) cfg_out.q_offset[9:2] == q.r_q_ofs_hi
        && cfg_out.q_offset[1:0] == q.r_q_ofs_lo[1:0])
        else $error("offset word assembled wrongly");

    a_sdio_follows_rw: assert property (@(posedge core_clk_in)
        disable iff (rst) q.r_iface[`DCR_BIT_SDIO_BIDIR] && q.data_phase
        && !port_cs_n_in |-> sdio_oe_n_out == !q.read_op)
        else $error("sdio direction ignores instruction bit");

    a_msb_shift_in: assert property (@(posedge core_clk_in)
        disable iff (rst)
        sclk_rise && !q.r_iface[`DCR_BIT_LSB_FIRST]
        |=> q.shift_in[0] == $past(sdio_in))
        else $error("msb-first shift took wrong bit");

    a_reset_read_zero: assert property (@(posedge core_clk_in)
        disable iff (rst)
        byte_done && !q.data_phase && next_byte[4:0] == `DCR_ADDR_IFACE
        |=> !q.shift_out[`DCR_BIT_SOFT_RESET])
        else $error("soft reset bit shifted out as one");

    a_soft_reset_rest: assert property (@(posedge core_clk_in)
        disable iff (rst) soft_rst
        |=> q.r_input == `DCR_RST_INPUT && q.r_q_coarse == `DCR_RST_Q_COARSE
            && q.r_q_ofs_hi == `DCR_RST_Q_OFS_HI
            && q.r_q_ofs_lo == `DCR_RST_Q_OFS_LO)
        else $error("soft reset left a register off default");

    a_hard_reset_rest: assert property (@(posedge core_clk_in)
        rst |=> q.r_q_fine == `DCR_RST_Q_FINE
            && q.r_q_coarse == `DCR_RST_Q_COARSE
            && q.r_q_ofs_hi == `DCR_RST_Q_OFS_HI
            && q.r_q_ofs_lo == `DCR_RST_Q_OFS_LO)
        else $error("pin reset left a gain word off default");

    a_sleep_only: assert property (@(posedge core_clk_in)
        disable iff (rst) q.r_iface[`DCR_BIT_SLEEP]
        && !q.r_iface[`DCR_BIT_POWER_DOWN]
        |-> !dac_current_on_out && core_run_out)
        else $error("sleep did more than stop output currents");

    a_port_alive_down: assert property (@(posedge core_clk_in)
        disable iff (rst) q.r_iface[`DCR_BIT_POWER_DOWN] && sclk_rise
        |=> q.bit_cnt == $past(q.bit_cnt) + 3'd1)
        else $error("serial port stalled in power-down");

    a_one_resistor: assert property (@(posedge core_clk_in)
        disable iff (rst) wr_en && q.addr == `DCR_ADDR_IFACE
        |=> cfg_out.one_resistor == $past(next_byte[`DCR_BIT_ONE_RES]))
        else $error("resistor mode bit not taken");

    a_lock_read_path: assert property (@(posedge core_clk_in)
        disable iff (rst)
        byte_done && !q.data_phase && next_byte[4:0] == `DCR_ADDR_IFACE
        |=> q.shift_out[`DCR_BIT_PLL_LOCK] == $past(pll_locked_in))
        else $error("lock bit not loaded for readout");

    a_interp_write: assert property (@(posedge core_clk_in)
        disable iff (rst) wr_en && q.addr == `DCR_ADDR_INTERP
        |=> cfg_out.interp_sel == $past(next_byte[7:6]))
        else $error("interpolation field not taken");

    a_mod_write: assert property (@(posedge core_clk_in)
        disable iff (rst) wr_en && q.addr == `DCR_ADDR_INTERP
        |=> cfg_out.mod_sel == $past(next_byte[5:4]))
        else $error("modulation field not taken");

    a_zero_stuff: assert property (@(posedge core_clk_in)
        disable iff (rst) wr_en && q.addr == `DCR_ADDR_INTERP
        |=> cfg_out.zero_stuff == $past(next_byte[`DCR_BIT_ZERO_STUFF]))
        else $error("zero-stuff bit not taken");

    a_mix_default: assert property (@(posedge core_clk_in)
        rst |=> cfg_out.real_mix && !cfg_out.pos_exponent)
        else $error("mix mode not real after reset");

    a_exp_sign: assert property (@(posedge core_clk_in)
        disable iff (rst) wr_en && q.addr == `DCR_ADDR_INTERP
        |=> cfg_out.pos_exponent == $past(next_byte[`DCR_BIT_POS_EXP]))
        else $error("exponent sign bit not taken");

    a_rate_clock_inv: assert property (@(posedge core_clk_in)
        disable iff (rst)
        q.r_input[`DCR_BIT_ONE_PORT] || q.r_interp[`DCR_BIT_PIN_RATE_CLK]
        |-> rate_clock_out
            == (rate_clock_in != q.r_input[`DCR_BIT_RATE_INV]))
        else $error("rate clock pin polarity wrong");

    a_input_format: assert property (@(posedge core_clk_in)
        disable iff (rst) wr_en && q.addr == `DCR_ADDR_INPUT
        |=> cfg_out.offset_binary == $past(next_byte[`DCR_BIT_OFFSET_BIN]))
        else $error("input format bit not taken");

    a_port_mode: assert property (@(posedge core_clk_in)
        disable iff (rst) wr_en && q.addr == `DCR_ADDR_INPUT
        |=> cfg_out.one_port == $past(next_byte[`DCR_BIT_ONE_PORT]))
        else $error("port mode bit not taken");

    a_drive_strength: assert property (@(posedge core_clk_in)
        disable iff (rst) wr_en && q.addr == `DCR_ADDR_INPUT
        |=> cfg_out.strong_drive == $past(next_byte[`DCR_BIT_STRONG_DRV]))
        else $error("drive strength bit not taken");

    a_spclk_invert: assert property (@(posedge core_clk_in)
        disable iff (rst) single_port_clock_pin_out
        == (single_port_clock_in != q.r_input[`DCR_BIT_SPCLK_INV]))
        else $error("single-port clock polarity wrong");

    a_pair_order: assert property (@(posedge core_clk_in)
        disable iff (rst) wr_en && q.addr == `DCR_ADDR_INPUT
        |=> cfg_out.q_first == $past(next_byte[`DCR_BIT_Q_FIRST]))
        else $error("pair order bit not taken");

    a_fine_gain: assert property (@(posedge core_clk_in)
        disable iff (rst) wr_en && q.addr == `DCR_ADDR_Q_FINE
        |=> cfg_out.q_fine == $past(next_byte))
        else $error("fine gain word not taken");

    a_offset_dir: assert property (@(posedge core_clk_in)
        disable iff (rst) wr_en && q.addr == `DCR_ADDR_Q_OFS_LO
        |=> cfg_out.q_offset_to_b == $past(next_byte[`DCR_BIT_OFS_DIR]))
        else $error("offset direction bit not taken");

    a_undef_bits_zero: assert property (@(posedge core_clk_in)
        disable iff (rst) wr_en && q.addr == `DCR_ADDR_Q_COARSE
        |=> q.r_q_coarse[7:4] == 4'h0)
        else $error("undefined coarse bits stored");

endmodule // dcr_config_bank

// >>> sim/dcr_host_model.sv
// behavioural host processor on the serial control port
module dcr_host_model (
    input wire logic core_clk_in,
    input wire logic read_bit_in,
    input wire logic oe_n_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic sdio_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lsb_first = 1'b0;
    logic drove = 1'b0;
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdio_out = 1'b0;
    end
    // ------------------------------------------------------------
    // one bit: sclk low three cycles, sample, then high two
    // ------------------------------------------------------------
    task automatic bit_io(input logic b, output logic r);
        @(posedge core_clk_in);
        sclk_out <= 1'b0;
        sdio_out <= b;
        repeat (3) @(posedge core_clk_in);
        r = read_bit_in;
        sclk_out <= 1'b1;
        @(posedge core_clk_in);
    endtask
    // instruction byte then one data byte; a read keeps driving, toggling sdio each bit
    task automatic xfer(input logic [7:0] ins, input logic [7:0] wd,
            output logic [7:0] rd);
        logic r;
        int k;
        drove = 1'b0;
        @(posedge core_clk_in);
        cs_n_out <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            k = lsb_first ? i % 8 : 7 - i % 8;
            if (i < 8)
                bit_io(ins[k], r);
            else if (ins[7])
                bit_io(~sdio_out, r);
            else
                bit_io(wd[k], r);
            if (i > 7)
                rd[k] = r;
            if (i > 7 && !oe_n_in)
                drove = 1'b1;
        end
        @(posedge core_clk_in);
        sclk_out <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        cs_n_out <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        if (ins == 8'h00)
            lsb_first = wd[6];
    endtask
endmodule // dcr_host_model

// >>> sim/tb_dual_dac_config_registers.sv
// self-checking bench of the dual converter config register bank
module tb_dual_dac_config_registers
    import dcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, sys_rst, hw_rst, sclk, cs_n, host_sdio, sdio_line;
    logic pll_lock, rclk, spclk, csel;
    logic sdio_o, oe_n, sdo, rco, spo, toq, dac_on, run, host_rd;
    dcr_cfg_t cfg;
    int mismatches = 0;
    int check_count = 0;
    logic [4:0] at [9] = '{5'h00, 5'h01, 5'h02, 5'h09, 5'h0a, 5'h0b,
        5'h0c, 5'h0d, 5'h1f};
    logic [7:0] dt [9] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h01, 8'h00};
    logic [7:0] mt [9] = '{8'h00, 8'hff, 8'hf7, 8'hff, 8'h0f, 8'hff,
        8'h83, 8'h01, 8'h00};
    assign sdio_line = oe_n ? host_sdio : sdio_o;
    // the host reads the shared line once the bank drives it
    assign host_rd = oe_n ? sdo : sdio_line;
    dcr_config_bank dut (
        .core_clk_in(core_clk),
        .sys_rst_in(sys_rst),
        .hw_reset_pin_in(hw_rst),
        .port_sclk_in(sclk),
        .port_cs_n_in(cs_n),
        .sdio_in(sdio_line),
        .sdio_out(sdio_o),
        .sdio_oe_n_out(oe_n),
        .sdo_out(sdo),
        .pll_locked_in(pll_lock),
        .rate_clock_in(rclk),
        .single_port_clock_in(spclk),
        .channel_select_input_in(csel),
        .rate_clock_out(rco),
        .single_port_clock_pin_out(spo),
        .route_to_q_out(toq),
        .dac_current_on_out(dac_on),
        .core_run_out(run),
        .cfg_out(cfg)
    );
    dcr_host_model host (
        .core_clk_in(core_clk),
        .read_bit_in(host_rd),
        .oe_n_in(oe_n),
        .sclk_out(sclk),
        .cs_n_out(cs_n),
        .sdio_out(host_sdio)
    );
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [9:0] e,
            input logic [9:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] r;
        host.xfer({3'h0, a}, d, r);
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        host.xfer({3'h4, a}, 8'h00, d);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_defaults;
        logic [7:0] v;
        for (int i = 0; i < 9; i++) begin
            rd(at[i], v);
            chk("reset value", dt[i], v);
        end
        chk("run after reset", 2'h3, {run, dac_on});
    endtask
    task automatic t_fields;
        logic [7:0] v;
        for (int i = 1; i < 9; i++) begin
            wr(at[i], 8'hff);
            rd(at[i], v);
            chk("readback", mt[i], v);
        end
        chk("offset all", 10'h3ff, cfg.q_offset);
        chk("coarse", 4'hf, cfg.q_coarse);
        wr(5'h0b, 8'h80);
        wr(5'h0c, 8'h01);
        chk("offset", 10'h201, cfg.q_offset);
        chk("offset dir", 1'b0, cfg.q_offset_to_b);
        wr(5'h0c, 8'h82);
        chk("offset b", 10'h202, cfg.q_offset);
        chk("offset dir b", 1'b1, cfg.q_offset_to_b);
        for (int m = 0; m < 4; m++) begin
            wr(5'h01, {m[1:0], m[1:0], m[0], ~m[0], m[1], 1'b0});
            chk("mode", {m[1:0], m[1:0], m[0], ~m[0], m[1]}, {cfg.interp_sel,
                cfg.mod_sel, cfg.zero_stuff, cfg.real_mix,
                cfg.pos_exponent});
        end
    endtask
    task automatic t_pins;
        logic [2:0] e;
        for (int j = 0; j < 4; j++) begin
            wr(5'h01, {7'h02, j[0]});
            wr(5'h02, {j[0], j[1], j[0], j[0] ^ j[1], 1'b0, j[0], j[1],
                j[0]});
            chk("input cfg", {j[0], j[1], j[0], j[0]},
                {cfg.offset_binary, cfg.one_port, cfg.strong_drive,
                cfg.q_first});
            for (int x = 0; x < 8; x++) begin
                @(posedge core_clk);
                {pll_lock, rclk, spclk, csel} <= {x[0], x[1], x[2],
                    x[0] ^ x[1]};
                @(posedge core_clk);
                e[2] = (j[1:0] == 2'h0) ? x[0] : x[1] ^ j[0] ^ j[1];
                e[1] = x[2] ^ j[0];
                e[0] = x[0] ^ x[1] ^ j[1];
                chk("pins", e, {rco, spo, toq});
            end
        end
    endtask
    task automatic t_power;
        logic [7:0] v;
        @(posedge core_clk);
        pll_lock <= 1'b1;
        wr(5'h00, 8'h0c);
        chk("power down", 3'h1,
            {run, dac_on, cfg.one_resistor});
        rd(5'h00, v);
        chk("reg0 locked", 8'h0e, v);
        @(posedge core_clk);
        pll_lock <= 1'b0;
        wr(5'h00, 8'h10);
        chk("sleep", 2'h2, {run, dac_on});
        rd(5'h00, v);
        chk("reg0 unlocked", 8'h10, v);
    endtask
    task automatic t_resets;
        logic [7:0] v;
        wr(5'h01, 8'h3c);
        wr(5'h09, 8'h5a);
        wr(5'h00, 8'h24);
        rd(5'h00, v);
        chk("reg0 kept", 8'h04, v);
        rd(5'h01, v);
        chk("reg1 restored", 8'h04, v);
        rd(5'h09, v);
        chk("fine restored", 8'h00, v);
        chk("coarse restored", 4'h0, cfg.q_coarse);
        wr(5'h0a, 8'h05);
        @(posedge core_clk);
        hw_rst <= 1'b1;
        @(posedge core_clk);
        hw_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        rd(5'h00, v);
        chk("reg0 pin reset", 8'h00, v);
        chk("coarse pin reset", 4'h0, cfg.q_coarse);
    endtask
    task automatic t_order;
        logic [7:0] v;
        wr(5'h00, 8'h40);
        wr(5'h09, 8'h96);
        chk("lsb first", 8'h96, cfg.q_fine);
        wr(5'h00, 8'hc0);
        rd(5'h09, v);
        chk("bidir read", 9'h196, {host.drove, v});
        wr(5'h00, 8'h00);
        rd(5'h09, v);
        chk("input only", 9'h096, {host.drove, v});
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        mismatches++;
        stop_test();
    end
    initial begin
        sys_rst = 1'b1;
        hw_rst = 1'b0;
        {pll_lock, rclk, spclk, csel} = 4'h0;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        t_defaults();
        t_fields();
        t_pins();
        t_power();
        t_resets();
        t_order();
        stop_test();
    end
endmodule // tb_dual_dac_config_registers
